// >>> design/agu_pkg.sv
// Package: constants and types for the address generation unit
package agu_pkg;
  // ----------------------------------------
  // Widths and register indices
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int PC_W = 23;
  localparam int FILE_W = 13;
  localparam int NREG = 16;
  localparam int PC_SPLIT = 16;
  localparam int STAT_LOW_W = 8;
  localparam int LIT5_W = 5;
  localparam int LIT10_W = 10;
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [3:0] FP_IDX = 4'he;
  localparam logic [3:0] IMPLIED_WORKING_REG_IDX = 4'h0;
  // ----------------------------------------
  // Reset values and steps
  // ----------------------------------------
  localparam logic [15:0] SP_RESET = 16'h1000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  // ----------------------------------------
  // Modes and stack operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    AM_FILE, AM_REG, AM_IND, AM_POST, AM_PRE, AM_INDEX, AM_LITOFF, AM_LIT5, AM_LIT10
  } addr_mode_e;
  typedef enum logic [2:0] {SK_NONE, SK_PUSH, SK_POP, SK_CALL, SK_EXC, SK_RET} stack_op_e;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    addr_mode_e mode;
    logic [3:0] ptr_sel;
    logic [3:0] base_sel;
    logic [15:0] lit;
    logic [12:0] faddr;
  } addr_req_s;
  typedef struct packed {
    logic [15:0] addr;
    logic we;
    logic re;
    logic [15:0] wdata;
    logic paged_ok;
  } mem_req_s;
endpackage : agu_pkg

// >>> design/cpu_address_generation.sv
// Module: effective-address generation and software stack control
// Summary of operation
// - Stack pointer resets to 0x1000
// - Stack pointer bit 0 always zero
// - Pointer marks first free word, grows upward
// - Push writes then increments; pop decrements then reads
// - PC low word first, high bits next
// - Call pushes zero-filled upper byte
// - Exception pushes status low byte with PC
// - Stack pointer never paged; frame pointer unpaged only with frame_pointer_select
// - Automatic stack updates; pointer stays ordinary register
// - File direct uses 13-bit field only
// - File instructions use working register zero
// - Base register direct, second register or literal
// - Five or ten bit literal operands
// - Indirect: address is pointer, unchanged
// - Post-modified: address then pointer adjusted
// - Pre-modified: adjusted pointer is address
// - Indexed: pointer plus base register
// - Literal offset: pointer plus literal
`timescale 1ns/1ps
module cpu_address_generation (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Decoder requests
  input agu_pkg::addr_req_s req,
  input agu_pkg::stack_op_e stk_op,
  input wire logic [15:0] push_data,
  input wire logic [agu_pkg::PC_W-1:0] pc,
  input wire logic [agu_pkg::STAT_LOW_W-1:0] status_low_byte,
  input wire logic frame_pointer_select,
  // Working register write port
  input wire logic implied_working_reg_we,
  input wire logic [3:0] implied_working_reg_sel,
  input wire logic [15:0] implied_working_reg_data,
  // Data memory
  output agu_pkg::mem_req_s mem,
  input wire logic [15:0] mem_rdata,
  // Results
  output logic [15:0] operand_a,
  output logic [15:0] operand_b,
  output logic ea_valid,
  output logic [15:0] pop_data,
  output logic pop_valid,
  output logic [agu_pkg::PC_W-1:0] ret_pc,
  output logic [agu_pkg::STAT_LOW_W-1:0] ret_status,
  output logic ret_valid,
  output logic busy,
  output logic [15:0] stack_pointer_reg
);
  import agu_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_PUSH_HI, ST_RET_LO, ST_RET_END, ST_POP_END} stk_state_e;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] implied_working_reg [NREG];
  stk_state_e state;
  logic [15:0] hi_word;
  logic [6:0] ret_hi;
  logic [7:0] ret_sr;

  // Add with 16-bit wrap, never extended
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    add16 = a + b;
  endfunction : add16

  // Value as stored into a given register
  // stack pointer bit 0 cleared
  function automatic logic [15:0] store_val(input logic [3:0] idx, input logic [15:0] v);
    store_val = (idx == SP_IDX) ? {v[15:1], 1'b0} : v;
  endfunction : store_val

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  logic take_stk;
  logic take_am;
  logic [15:0] sp;
  logic [15:0] ptr_val;
  logic [15:0] base_val;
  assign take_stk = (state == ST_IDLE) && (stk_op != SK_NONE);
  assign take_am = (state == ST_IDLE) && (stk_op == SK_NONE) && req.valid;
  assign sp = implied_working_reg[SP_IDX];
  assign ptr_val = implied_working_reg[req.ptr_sel];
  assign base_val = implied_working_reg[req.base_sel];

  // ----------------------------------------
  // Effective address per mode
  // ----------------------------------------
  logic [15:0] next_ea;
  logic next_ptr_we;
  logic [15:0] next_ptr;
  logic [15:0] next_opb;
  logic next_mem;
  always_comb begin
    next_ea = ptr_val;
    next_ptr_we = 1'b0;
    next_ptr = ptr_val;
    next_opb = 16'h0000;
    next_mem = 1'b1;
    case (req.mode)
      AM_FILE: next_ea = {{(DATA_W-FILE_W){1'b0}}, req.faddr};
      AM_REG: begin
        next_mem = 1'b0;
        next_opb = ptr_val;
      end
      AM_IND: next_ea = ptr_val;
      AM_POST: begin
        next_ea = ptr_val;
        next_ptr_we = 1'b1;
        next_ptr = add16(ptr_val, req.lit);
      end
      AM_PRE: begin
        next_ea = add16(ptr_val, req.lit);
        next_ptr_we = 1'b1;
        next_ptr = add16(ptr_val, req.lit);
      end
      AM_INDEX: next_ea = add16(ptr_val, base_val);
      AM_LITOFF: next_ea = add16(ptr_val, req.lit);
      AM_LIT5: begin
        next_mem = 1'b0;
        next_opb = {{(DATA_W-LIT5_W){1'b0}}, req.lit[LIT5_W-1:0]};
      end
      AM_LIT10: begin
        next_mem = 1'b0;
        next_opb = {{(DATA_W-LIT10_W){1'b0}}, req.lit[LIT10_W-1:0]};
      end
      default: next_mem = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Stack sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_stk && (stk_op == SK_CALL || stk_op == SK_EXC)) begin
            state <= ST_PUSH_HI;
          end else if (take_stk && stk_op == SK_RET) begin
            state <= ST_RET_LO;
          end else if (take_stk && stk_op == SK_POP) begin
            state <= ST_POP_END;
          end
        end
        ST_RET_LO: state <= ST_RET_END;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Upper stacked word, built at entry
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_word <= 16'h0000;
    end else if (take_stk && stk_op == SK_CALL) begin
      hi_word <= {9'h000, pc[PC_W-1:PC_SPLIT]};
    end else if (take_stk && stk_op == SK_EXC) begin
      hi_word <= {status_low_byte, 1'b0, pc[PC_W-1:PC_SPLIT]};
    end
  end

  // ----------------------------------------
  // Working registers, stack pointer included
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++) begin
        implied_working_reg[i] <= REG_RESET;
      end
      implied_working_reg[SP_IDX] <= SP_RESET;
    end else begin
      if (implied_working_reg_we) begin
        implied_working_reg[implied_working_reg_sel] <= store_val(implied_working_reg_sel, implied_working_reg_data);
      end
      if (take_am && next_ptr_we) begin
        implied_working_reg[req.ptr_sel] <= store_val(req.ptr_sel, next_ptr);
      end
      if ((take_stk && stk_op != SK_RET && stk_op != SK_POP) || state == ST_PUSH_HI) begin
        implied_working_reg[SP_IDX] <= store_val(SP_IDX, add16(sp, STACK_STEP));
      end else if ((take_stk && (stk_op == SK_RET || stk_op == SK_POP)) ||
                   state == ST_RET_LO) begin
        implied_working_reg[SP_IDX] <= store_val(SP_IDX, sp - STACK_STEP);
      end
    end
  end
  assign stack_pointer_reg = implied_working_reg[SP_IDX];

  // ----------------------------------------
  // Memory port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem <= '0;
    end else begin
      mem.we <= 1'b0;
      mem.re <= 1'b0;
      mem.paged_ok <= 1'b0;
      // low word at first free word, high word after
      if (take_stk && stk_op != SK_RET && stk_op != SK_POP) begin
        mem.addr <= sp;
        mem.we <= 1'b1;
        mem.wdata <= (stk_op == SK_PUSH) ? push_data : pc[PC_SPLIT-1:0];
      end else if (state == ST_PUSH_HI) begin
        mem.addr <= sp;
        mem.we <= 1'b1;
        mem.wdata <= hi_word;
      end else if ((take_stk && (stk_op == SK_RET || stk_op == SK_POP)) ||
                   state == ST_RET_LO) begin
        mem.addr <= sp - STACK_STEP;
        mem.re <= 1'b1;
      end else if (take_am && next_mem) begin
        mem.addr <= next_ea;
        mem.re <= 1'b1;
        // stack pointer stays unpaged; frame pointer only while frame_pointer_select is set
        mem.paged_ok <= (req.mode != AM_FILE) && (req.ptr_sel != SP_IDX) &&
                        !(req.ptr_sel == FP_IDX && frame_pointer_select);
      end
    end
  end

  // ----------------------------------------
  // Operands
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      operand_a <= 16'h0000;
      operand_b <= 16'h0000;
      ea_valid <= 1'b0;
    end else begin
      ea_valid <= take_am;
      if (take_am) begin
        // implied register for file mode, else base direct
        operand_a <= (req.mode == AM_FILE) ? implied_working_reg[IMPLIED_WORKING_REG_IDX] : base_val;
        operand_b <= next_opb;
      end
    end
  end

  // ----------------------------------------
  // Pop and return results
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ret_hi <= 7'h00;
      ret_sr <= 8'h00;
      ret_pc <= '0;
      ret_status <= 8'h00;
      ret_valid <= 1'b0;
      pop_data <= 16'h0000;
      pop_valid <= 1'b0;
    end else begin
      ret_valid <= (state == ST_RET_END);
      pop_valid <= (state == ST_POP_END);
      if (state == ST_RET_LO) begin
        ret_hi <= mem_rdata[PC_W-PC_SPLIT-1:0];
        ret_sr <= mem_rdata[15:8];
      end
      if (state == ST_RET_END) begin
        ret_pc <= {ret_hi, mem_rdata};
        ret_status <= ret_sr;
      end
      if (state == ST_POP_END) begin
        pop_data <= mem_rdata;
      end
    end
  end

  // Busy while a call, exception, return or pop runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= (take_stk && stk_op != SK_PUSH) || state == ST_RET_LO;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_call_taken;
    take_stk && stk_op == SK_CALL;
  endsequence
  sequence s_push_taken;
    take_stk && stk_op == SK_PUSH;
  endsequence
  sequence s_ret_taken;
    take_stk && stk_op == SK_RET;
  endsequence

  chk_sp_align: assert property (@(posedge clk) disable iff (!rstn)
    stack_pointer_reg[0] == 1'b0) else $error("stack pointer bit 0 set");
  chk_sp_reset: assert property (@(posedge clk)
    !rstn |=> stack_pointer_reg == SP_RESET || !rstn) else $error("bad pointer reset");
  chk_push_order: assert property (@(posedge clk) disable iff (!rstn)
    s_push_taken |=> mem.we && mem.addr == $past(sp) && sp == add16($past(sp), STACK_STEP))
    else $error("push order wrong");
  chk_call_words: assert property (@(posedge clk) disable iff (!rstn)
    s_call_taken |=> mem.we && mem.wdata == $past(pc[15:0]) ##1 mem.we &&
    mem.addr == add16($past(mem.addr), STACK_STEP)) else $error("call words wrong");
  chk_call_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_call_taken |-> ##2 mem.wdata[15:7] == 9'h000) else $error("call upper byte not zero");
  chk_exc_status: assert property (@(posedge clk) disable iff (!rstn)
    take_stk && stk_op == SK_EXC |-> ##2 mem.wdata[15:8] == $past(status_low_byte, 2))
    else $error("status byte not stacked");
  chk_pop_first: assert property (@(posedge clk) disable iff (!rstn)
    take_stk && stk_op == SK_POP |=> mem.re && mem.addr == sp ##1 pop_valid)
    else $error("pop order wrong");
  chk_ind_ea: assert property (@(posedge clk) disable iff (!rstn)
    take_am && req.mode == AM_IND |=> mem.re && mem.addr == $past(ptr_val))
    else $error("indirect address wrong");
  chk_file_near: assert property (@(posedge clk) disable iff (!rstn)
    take_am && req.mode == AM_FILE |=> mem.addr[15:13] == 3'h0) else $error("file addr too wide");
  chk_sp_unpaged: assert property (@(posedge clk) disable iff (!rstn)
    take_am && req.ptr_sel == SP_IDX |=> !mem.paged_ok) else $error("stack pointer paged");
  chk_ret_order: assert property (@(posedge clk) disable iff (!rstn)
    s_ret_taken |=> mem.re && mem.addr == sp ##1 mem.re && mem.addr == sp ##1 ret_valid)
    else $error("return order wrong");
  chk_push_idle: assert property (@(posedge clk) disable iff (!rstn)
    s_push_taken |=> !busy) else $error("push left unit busy");
  chk_pre_ea: assert property (@(posedge clk) disable iff (!rstn)
    take_am && req.mode == AM_PRE |=>
    mem.re && mem.addr == add16($past(ptr_val), $past(req.lit))) else $error("pre address wrong");
  chk_index_ea: assert property (@(posedge clk) disable iff (!rstn)
    take_am && req.mode == AM_INDEX |=>
    mem.re && mem.addr == add16($past(ptr_val), $past(base_val))) else $error("index addr wrong");
  chk_litoff_ea: assert property (@(posedge clk) disable iff (!rstn)
    take_am && req.mode == AM_LITOFF |=>
    mem.re && mem.addr == add16($past(ptr_val), $past(req.lit))) else $error("offset addr wrong");
endmodule : cpu_address_generation

// >>> bench/agu_mem_model.sv
// Data memory model facing the address generation unit
`timescale 1ns/1ps
module agu_mem_model (
  // Clock
  input wire logic clk,
  // Memory bus
  input agu_pkg::mem_req_s mem,
  output logic [15:0] mem_rdata
);
  import agu_pkg::*;
  logic [15:0] ram [0:32767];
  logic [15:0] hold;
  logic held;
  logic [15:0] junk = 16'h3c3c;
  // Store writes, keep read word a cycle, churn idle pattern
  always @(posedge clk) begin
    if (mem.we) begin
      ram[mem.addr[15:1]] <= mem.wdata;
    end
    held <= mem.re;
    hold <= ram[mem.addr[15:1]];
    junk <= {junk[14:0], ~junk[15]};
  end
  // The cycle after a read repeats that word; other undriven cycles show a changing pattern
  assign mem_rdata = mem.re ? ram[mem.addr[15:1]] : (held ? hold : junk);
endmodule : agu_mem_model

// >>> bench/cpu_address_generation_tb_top.sv
// Testbench for the address generation unit
`timescale 1ns/1ps
module cpu_address_generation_tb_top;
  import agu_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  addr_req_s req = '0;
  stack_op_e stk_op = SK_NONE;
  logic [15:0] push_data = '0;
  logic [22:0] pc = '0;
  logic [7:0] status_low_byte = '0;
  logic frame_pointer_select = 1'b0;
  logic implied_working_reg_we = 1'b0;
  logic [3:0] implied_working_reg_sel = '0;
  logic [15:0] implied_working_reg_data = '0;
  mem_req_s mem;
  logic [15:0] mem_rdata, operand_a, operand_b, pop_data, sp, got_pop;
  logic ea_valid, pop_valid, ret_valid, busy;
  logic [22:0] ret_pc, got_pc;
  logic [7:0] ret_status, got_st;
  int errors = 0;
  int checked = 0;
  always #5 clk = ~clk;
  cpu_address_generation u_cpu_address_generation (.clk(clk), .rstn(rstn), .req(req),
    .stk_op(stk_op), .push_data(push_data), .pc(pc), .status_low_byte(status_low_byte),
    .frame_pointer_select(frame_pointer_select), .implied_working_reg_we(implied_working_reg_we), .implied_working_reg_sel(implied_working_reg_sel),
    .implied_working_reg_data(implied_working_reg_data), .mem(mem), .mem_rdata(mem_rdata), .operand_a(operand_a),
    .operand_b(operand_b), .ea_valid(ea_valid), .pop_data(pop_data), .pop_valid(pop_valid),
    .ret_pc(ret_pc), .ret_status(ret_status), .ret_valid(ret_valid), .busy(busy),
    .stack_pointer_reg(sp));
  agu_mem_model u_mem (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));
  // Capture one-cycle result pulses
  always @(posedge clk) begin
    if (ret_valid) begin
      got_pc = ret_pc;
      got_st = ret_status;
    end
    if (pop_valid) begin
      got_pop = pop_data;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge clk);
    implied_working_reg_we <= 1'b1;
    implied_working_reg_sel <= s;
    implied_working_reg_data <= d;
    @(posedge clk);
    implied_working_reg_we <= 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic ea(input addr_mode_e m, input logic [3:0] p, input logic [15:0] l);
    @(posedge clk);
    req <= '{valid: 1'b1, mode: m, ptr_sel: p, base_sel: 4'h3, lit: l, faddr: 13'h1fff};
    @(posedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
    check(ea_valid, 1, "ea_valid");
  endtask : ea
  task automatic stack(input stack_op_e op, input logic [15:0] d, input logic [22:0] p,
                       input logic [7:0] s);
    @(posedge clk);
    stk_op <= op;
    push_data <= d;
    pc <= p;
    status_low_byte <= s;
    @(posedge clk);
    stk_op <= SK_NONE;
    @(negedge clk);
    check(busy, op != SK_PUSH, "busy in sequence");
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : stack
  function automatic logic [15:0] word(input logic [15:0] a);
    return u_mem.ram[a[15:1]];
  endfunction : word
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_stack;
    check(sp, 16'h1000, "sp after reset");
    wr(4'hf, 16'h2001);
    check(sp, 16'h2000, "sp odd write");
    wr(4'hf, 16'h1000);
    @(posedge clk);
    stk_op <= SK_PUSH;
    push_data <= 16'hbeef;
    @(posedge clk);
    push_data <= 16'hcafe;
    @(posedge clk);
    stk_op <= SK_NONE;
    repeat (2) @(negedge clk);
    check(busy, 0, "push busy");
    check(sp, 16'h1004, "sp after pushes");
    check(word(16'h1000), 16'hbeef, "first push");
    check(word(16'h1002), 16'hcafe, "second push");
    stack(SK_CALL, 16'h0, 23'h5a1234, 8'ha5);
    check(word(16'h1004), 16'h1234, "call low");
    check(word(16'h1006), 16'h005a, "call high");
    stack(SK_EXC, 16'h0, 23'h7f0abc, 8'ha5);
    check(word(16'h1008), 16'h0abc, "exc low");
    check(word(16'h100a), 16'ha57f, "exc high");
    check(sp, 16'h100c, "sp after frames");
    stack(SK_RET, 16'h0, 23'h0, 8'h0);
    check({got_st, got_pc}, {8'ha5, 23'h7f0abc}, "ret exc");
    stack(SK_RET, 16'h0, 23'h0, 8'h0);
    check({got_st, got_pc}, {8'h00, 23'h5a1234}, "ret call");
    stack(SK_POP, 16'h0, 23'h0, 8'h0);
    check(got_pop, 16'hcafe, "pop one");
    stack(SK_POP, 16'h0, 23'h0, 8'h0);
    check(got_pop, 16'hbeef, "pop two");
    check(sp, 16'h1000, "sp after pops");
    $display("test stack done");
  endtask : t_stack
  task automatic t_reset;
    wr(4'hf, 16'h0ab0);
    check(sp, 16'h0ab0, "sp before reset");
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check(sp, 16'h1000, "sp in reset");
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(sp, 16'h1000, "sp after mid-run reset");
    check({busy, ea_valid, mem.we, mem.re, ret_pc}, 27'h0, "outputs after reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    wr(4'h0, 16'h0777);
    wr(4'h2, 16'h0100);
    wr(4'h3, 16'h0010);
    ea(AM_IND, 4'h2, 16'h0);
    check({mem.re, mem.addr}, {1'b1, 16'h0100}, "indirect");
    ea(AM_POST, 4'h2, 16'h0002);
    check(mem.addr, 16'h0100, "post addr");
    ea(AM_IND, 4'h2, 16'h0);
    check(mem.addr, 16'h0102, "post update");
    ea(AM_PRE, 4'h2, 16'hfffe);
    check(mem.addr, 16'h0100, "pre addr");
    ea(AM_IND, 4'h2, 16'h0);
    check(mem.addr, 16'h0100, "pre update");
    ea(AM_INDEX, 4'h2, 16'h0);
    check({mem.paged_ok, mem.addr}, {1'b1, 16'h0110}, "indexed");
    ea(AM_LITOFF, 4'h2, 16'h0020);
    check(mem.addr, 16'h0120, "lit offset");
    ea(AM_IND, 4'hf, 16'h0);
    check({mem.paged_ok, mem.addr}, {1'b0, 16'h1000}, "sp unpaged");
    wr(4'he, 16'h0200);
    ea(AM_IND, 4'he, 16'h0);
    check({mem.paged_ok, mem.addr}, {1'b1, 16'h0200}, "fp paged");
    @(posedge clk);
    frame_pointer_select <= 1'b1;
    ea(AM_IND, 4'he, 16'h0);
    check(mem.paged_ok, 0, "fp unpaged");
    ea(AM_FILE, 4'h2, 16'h0);
    check({mem.paged_ok, mem.addr}, {1'b0, 16'h1fff}, "file addr");
    check(operand_a, 16'h0777, "file implied_working_reg");
    ea(AM_LIT5, 4'h2, 16'hffff);
    check({operand_a, operand_b}, {16'h0010, 16'h001f}, "lit5");
    ea(AM_LIT10, 4'h2, 16'hffff);
    check(operand_b, 16'h03ff, "lit10");
    ea(AM_REG, 4'h2, 16'h0);
    check({operand_a, operand_b}, {16'h0010, 16'h0100}, "reg direct");
    check(mem.re, 0, "reg direct no fetch");
    $display("test modes done");
  endtask : t_modes
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_stack();
    t_reset();
    t_modes();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule : cpu_address_generation_tb_top
